/* core/emb_bus_sequencer.sv */
// External bus sequencer: code fetch, data read, data write and port access.
`timescale 1ns/1ps
module emb_bus_sequencer
    import emb_pkg::*;
#(
    parameter int PORT_W = 8
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] req_kind,
    input wire logic [15:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic address_latch_strobe,
    output logic program_read_strobe_n,
    output logic data_read_strobe_n,
    output logic data_write_strobe_n,
    input wire logic [7:0] muxed_low_address_data_port_in,
    output logic [7:0] muxed_low_address_data_port_out,
    output logic muxed_low_address_data_port_oe,
    output logic [7:0] high_address_port,
    input wire logic [PORT_W-1:0] gen_port_pins_in,
    output logic [PORT_W-1:0] gen_port_pins_out,
    input wire logic [PORT_W-1:0] gen_port_wdata,
    input wire logic gen_port_wr,
    output logic [PORT_W-1:0] gen_port_rdata,
    output logic fifth_state_second_phase,
    output logic sixth_state_second_phase
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // True while a count lies in the half-open window [lo, hi).
    function automatic logic in_window(input logic [PH_W-1:0] n,
                                       input logic [PH_W-1:0] lo,
                                       input logic [PH_W-1:0] hi);
        in_window = (n >= lo) && (n < hi);
    endfunction

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    // Current bus cycle kind, or idle.
    emb_state_t state_reg;
    emb_state_t state_next;
    // Oscillator periods elapsed since the cycle began.
    logic [PH_W-1:0] cnt_reg;
    logic [PH_W-1:0] cnt_next;
    // Count that the next edge will hold; strobes are decoded from it so
    // that every pin comes straight out of a flip-flop.
    logic [PH_W-1:0] cnt_inc;
    // Write data of the current cycle.
    logic [7:0] wdata_reg;
    logic [7:0] wdata_next;
    // Pin registers.
    logic ale_reg;
    logic ale_next;
    logic prs_n_reg;
    logic prs_n_next;
    logic drs_n_reg;
    logic drs_n_next;
    logic dws_n_reg;
    logic dws_n_next;
    logic [7:0] mux_out_reg;
    logic [7:0] mux_out_next;
    logic mux_oe_reg;
    logic mux_oe_next;
    logic [7:0] high_reg;
    logic [7:0] high_next;
    // Answer registers.
    logic rsp_valid_reg;
    logic rsp_valid_next;
    logic [7:0] rsp_data_reg;
    logic [7:0] rsp_data_next;

    assign cnt_inc = cnt_reg + 1'b1;
    // A new request is taken only between bus cycles.
    assign req_ready = (state_reg == EMB_IDLE);
    assign address_latch_strobe = ale_reg;
    assign program_read_strobe_n = prs_n_reg;
    assign data_read_strobe_n = drs_n_reg;
    assign data_write_strobe_n = dws_n_reg;
    assign muxed_low_address_data_port_out = mux_out_reg;
    assign muxed_low_address_data_port_oe = mux_oe_reg;
    assign high_address_port = high_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_data = rsp_data_reg;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // The sequencer is purely edge counted; it has no timer that runs on
    // its own, so a halted clock simply freezes the cycle in place.
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        wdata_next = wdata_reg;
        ale_next = ale_reg;
        prs_n_next = prs_n_reg;
        drs_n_next = drs_n_reg;
        dws_n_next = dws_n_reg;
        mux_out_next = mux_out_reg;
        mux_oe_next = mux_oe_reg;
        high_next = high_reg;
        rsp_valid_next = 1'b0;
        rsp_data_next = rsp_data_reg;
        case (state_reg)
            EMB_IDLE:
            begin
                // Address goes out with the latch strobe rising; it stays two
                // periods before the latch falls, more than the one needed.
                if (req_valid)
                begin
                    cnt_next = '0;
                    wdata_next = req_wdata;
                    ale_next = 1'b1;
                    mux_out_next = req_addr[7:0];
                    mux_oe_next = 1'b1;
                    high_next = req_addr[15:8];
                    case (req_kind)
                        EMB_DATA_READ: state_next = EMB_DREAD;
                        EMB_DATA_WRITE: state_next = EMB_DWRITE;
                        default: state_next = EMB_FETCH;
                    endcase
                end
                else
                begin
                    mux_oe_next = 1'b0;
                end
            end
            EMB_FETCH:
            begin
                cnt_next = cnt_inc;
                ale_next = (cnt_inc < PH_ALE_FALL);
                // Address held one period past the latch, then the port
                // floats for the memory; its value and the high port stay put.
                mux_oe_next = (cnt_inc < PH_ADDR_OFF);
                prs_n_next = !in_window(cnt_inc, PH_PRS_LOW, PH_PRS_HIGH);
                // The byte is taken on the same edge that raises the strobe,
                // so it is inside before the strobe is seen high.
                if (cnt_inc == PH_PRS_HIGH)
                begin
                    rsp_data_next = muxed_low_address_data_port_in;
                end
                // One idle period after the strobe leaves room for the
                // memory to release the port before the next address.
                if (cnt_reg == PH_FETCH_LAST)
                begin
                    state_next = EMB_IDLE;
                    rsp_valid_next = 1'b1;
                end
            end
            EMB_DREAD:
            begin
                cnt_next = cnt_inc;
                ale_next = (cnt_inc < PH_ALE_FALL);
                mux_oe_next = (cnt_inc < PH_ADDR_OFF);
                drs_n_next = !in_window(cnt_inc, PH_DST_LOW, PH_DST_HIGH);
                if (cnt_inc == PH_DST_HIGH)
                begin
                    rsp_data_next = muxed_low_address_data_port_in;
                end
                // Two periods after the strobe let the memory float the port.
                if (cnt_reg == PH_DATA_LAST)
                begin
                    state_next = EMB_IDLE;
                    rsp_valid_next = 1'b1;
                end
            end
            EMB_DWRITE:
            begin
                cnt_next = cnt_inc;
                ale_next = (cnt_inc < PH_ALE_FALL);
                // Address held one period, then write data two periods
                // ahead of the strobe; the port stays driven to the end.
                if (cnt_inc == PH_ADDR_OFF)
                begin
                    mux_out_next = wdata_reg;
                end
                dws_n_next = !in_window(cnt_inc, PH_DST_LOW, PH_DST_HIGH);
                // Data remains until the last count, two periods after the rise.
                if (cnt_reg == PH_DATA_LAST)
                begin
                    state_next = EMB_IDLE;
                    mux_oe_next = 1'b0;
                    rsp_valid_next = 1'b1;
                end
            end
            default:
            begin
                state_next = EMB_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Strobes reset inactive and the muxed port floats.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= EMB_IDLE;
            cnt_reg <= '0;
            wdata_reg <= '0;
            ale_reg <= 1'b0;
            prs_n_reg <= 1'b1;
            drs_n_reg <= 1'b1;
            dws_n_reg <= 1'b1;
            mux_out_reg <= '0;
            mux_oe_reg <= 1'b0;
            high_reg <= '0;
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            wdata_reg <= wdata_next;
            ale_reg <= ale_next;
            prs_n_reg <= prs_n_next;
            drs_n_reg <= drs_n_next;
            dws_n_reg <= dws_n_next;
            mux_out_reg <= mux_out_next;
            mux_oe_reg <= mux_oe_next;
            high_reg <= high_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_data_reg <= rsp_data_next;
        end
    end

    // ------------------------------------------------------------------
    // Port access
    // ------------------------------------------------------------------
    // Port pins run on their own machine-state grid, independent of bus use.
    emb_port_unit #(
        .WIDTH(PORT_W)
    ) u_port (
        .clock(clock),
        .rst_n(rst_n),
        .port_pins_in(gen_port_pins_in),
        .port_pins_out(gen_port_pins_out),
        .port_wdata(gen_port_wdata),
        .port_wr(gen_port_wr),
        .port_rdata(gen_port_rdata),
        .fifth_state_second_phase(fifth_state_second_phase),
        .sixth_state_second_phase(sixth_state_second_phase)
    );

endmodule // emb_bus_sequencer

/* core/emb_pkg.sv */
// Shared constants for the external memory bus sequencer and its port unit.
package emb_pkg;

    // ------------------------------------------------------------------
    // Clock and the oscillator period
    // ------------------------------------------------------------------
    // Period of the clock input in nanoseconds (10 MHz).
    localparam int CLK_PERIOD_NS = 100;
    // One oscillator period in nanoseconds; every bus phase counts in these.
    localparam int TCP_NS = 100;
    // Clock cycles per oscillator period, never below one.
    localparam int TCP_CYCLES = (TCP_NS / CLK_PERIOD_NS) < 1 ? 1 : (TCP_NS / CLK_PERIOD_NS);

    // ------------------------------------------------------------------
    // Bus cycle phase marks, in oscillator periods from cycle start
    // ------------------------------------------------------------------
    // Width of the phase counter.
    localparam int PH_W = 4;
    // Address latch strobe falls at this count (high for two periods).
    localparam logic [PH_W-1:0] PH_ALE_FALL = 4'(2 * TCP_CYCLES);
    // Address leaves the muxed port at this count (one period of hold).
    localparam logic [PH_W-1:0] PH_ADDR_OFF = 4'(3 * TCP_CYCLES);
    // Program read strobe low window: falls and rises at these counts.
    localparam logic [PH_W-1:0] PH_PRS_LOW = 4'(3 * TCP_CYCLES);
    localparam logic [PH_W-1:0] PH_PRS_HIGH = 4'(6 * TCP_CYCLES);
    // Last count of a code fetch; one period lets the memory release the port.
    localparam logic [PH_W-1:0] PH_FETCH_LAST = 4'(6 * TCP_CYCLES);
    // Data read or write strobe low window.
    localparam logic [PH_W-1:0] PH_DST_LOW = 4'(5 * TCP_CYCLES);
    localparam logic [PH_W-1:0] PH_DST_HIGH = 4'(11 * TCP_CYCLES);
    // Last count of a data cycle; two periods after the strobe rises.
    localparam logic [PH_W-1:0] PH_DATA_LAST = 4'(12 * TCP_CYCLES);

    // ------------------------------------------------------------------
    // Machine states for port access
    // ------------------------------------------------------------------
    // Width of the phase counter that runs through six states of two phases.
    localparam int MS_W = 4;
    // Last phase index of a machine cycle (twelve phases).
    localparam logic [MS_W-1:0] MS_LAST = 4'hb;
    // Index of the fifth state's second phase, where ports are sampled.
    localparam logic [MS_W-1:0] MS_FIFTH_SECOND = 4'h9;
    // Index of the sixth state's second phase, at whose end ports update.
    localparam logic [MS_W-1:0] MS_SIXTH_SECOND = 4'hb;
    // Reset value of port outputs (released high, as after reset).
    localparam logic [7:0] PORT_RESET = 8'hff;

    // ------------------------------------------------------------------
    // Request kinds and sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        EMB_CODE_FETCH = 2'h0,
        EMB_DATA_READ = 2'h1,
        EMB_DATA_WRITE = 2'h2
    } emb_kind_t;

    typedef enum {EMB_IDLE, EMB_FETCH, EMB_DREAD, EMB_DWRITE} emb_state_t;

endpackage

/* core/emb_port_unit.sv */
// General purpose port sampling and update on the machine state grid.
`timescale 1ns/1ps
module emb_port_unit
    import emb_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] port_pins_in,
    output logic [WIDTH-1:0] port_pins_out,
    input wire logic [WIDTH-1:0] port_wdata,
    input wire logic port_wr,
    output logic [WIDTH-1:0] port_rdata,
    output logic fifth_state_second_phase,
    output logic sixth_state_second_phase
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Two-stage synchroniser; the first stage feeds only the second.
    logic [WIDTH-1:0] sync1_reg;
    logic [WIDTH-1:0] sync2_reg;
    // Phase index within a machine cycle.
    logic [MS_W-1:0] phase_reg;
    logic [MS_W-1:0] phase_next;
    // Sampled port value as seen by the core.
    logic [WIDTH-1:0] rdata_reg;
    logic [WIDTH-1:0] rdata_next;
    // Pending write value and its flag, waiting for the update slot.
    logic [WIDTH-1:0] pend_reg;
    logic [WIDTH-1:0] pend_next;
    logic pend_valid_reg;
    logic pend_valid_next;
    // Driven port value.
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] out_next;

    assign fifth_state_second_phase = (phase_reg == MS_FIFTH_SECOND);
    assign sixth_state_second_phase = (phase_reg == MS_SIXTH_SECOND);
    assign port_rdata = rdata_reg;
    assign port_pins_out = out_reg;

    // ------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------
    // Every value is held in flip-flops only, so a stopped clock loses nothing.
    always_comb
    begin
        phase_next = (phase_reg == MS_LAST) ? '0 : phase_reg + 1'b1;
        rdata_next = rdata_reg;
        pend_next = pend_reg;
        pend_valid_next = pend_valid_reg;
        out_next = out_reg;
        // Inputs are read only in the fifth state's second phase.
        if (fifth_state_second_phase)
        begin
            rdata_next = sync2_reg;
        end
        // A write arriving in the update slot is kept for the next one,
        // so the pins only ever change at the documented moment.
        if (sixth_state_second_phase && pend_valid_reg)
        begin
            out_next = pend_reg;
            pend_valid_next = 1'b0;
        end
        if (port_wr)
        begin
            pend_next = port_wdata;
            pend_valid_next = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Plain registering of the values computed above.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            phase_reg <= '0;
            rdata_reg <= '0;
            pend_reg <= '0;
            pend_valid_reg <= 1'b0;
            out_reg <= WIDTH'(PORT_RESET);
        end
        else
        begin
            sync1_reg <= port_pins_in;
            sync2_reg <= sync1_reg;
            phase_reg <= phase_next;
            rdata_reg <= rdata_next;
            pend_reg <= pend_next;
            pend_valid_reg <= pend_valid_next;
            out_reg <= out_next;
        end
    end

endmodule // emb_port_unit

/* tb/emb_bus_props.sv */
// Concurrent checks on the ports of the external bus sequencer.
`timescale 1ns/1ps
module emb_bus_props
    import emb_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic address_latch_strobe,
    input wire logic program_read_strobe_n,
    input wire logic data_read_strobe_n,
    input wire logic data_write_strobe_n,
    input wire logic [7:0] muxed_low_address_data_port_in,
    input wire logic [7:0] muxed_low_address_data_port_out,
    input wire logic muxed_low_address_data_port_oe,
    input wire logic [7:0] high_address_port,
    input wire logic [7:0] gen_port_pins_out,
    input wire logic [7:0] gen_port_rdata,
    input wire logic fifth_state_second_phase,
    input wire logic sixth_state_second_phase
);
    // ------------------------------------------------------------------
    // One clock domain, so clock and reset are given once.
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Short local names keep each property on a few lines.
    wire logic ale = address_latch_strobe;
    wire logic oe = muxed_low_address_data_port_oe;
    wire logic [7:0] dout = muxed_low_address_data_port_out;

    a_ale_width: assert property ($rose(ale) |-> ##1 ale ##1 !ale)
        else $error("latch strobe not high for two periods");
    a_addr_setup: assert property ($fell(ale) |-> oe && $past(oe)
        && $stable(dout) && $stable(high_address_port))
        else $error("address not held around latch fall");
    a_fetch_stable: assert property (!program_read_strobe_n |-> $stable(dout)
        && $stable(high_address_port)) else $error("port moved during code fetch");
    a_prs_timing: assert property ($fell(program_read_strobe_n) |-> !$past(ale)
        && $past(ale, 2)) else $error("program strobe not one period after latch");
    a_prs_width: assert property ($fell(program_read_strobe_n) |->
        ##1 !program_read_strobe_n ##1 !program_read_strobe_n ##1 program_read_strobe_n)
        else $error("program strobe width");
    a_fetch_capture: assert property ($rose(program_read_strobe_n) |->
        rsp_data == $past(muxed_low_address_data_port_in) ##1 rsp_valid)
        else $error("fetched byte not captured before strobe rise");
    a_read_strobe: assert property ($fell(data_read_strobe_n) |->
        $past(ale, 4) && !$past(ale, 3) ##1 !data_read_strobe_n [*5] ##1 data_read_strobe_n)
        else $error("read strobe timing");
    a_write_setup: assert property ($fell(data_write_strobe_n) |->
        oe && $past(oe) && $stable(dout) ##1 !data_write_strobe_n [*5] ##1 data_write_strobe_n)
        else $error("write data setup or strobe width");
    a_write_hold: assert property ($rose(data_write_strobe_n) |-> oe && $stable(dout)
        ##1 oe && $stable(dout)) else $error("write data not held after strobe");
    a_port_update: assert property ($changed(gen_port_pins_out) |->
        $past(sixth_state_second_phase)) else $error("port output changed off its slot");
    a_port_sample: assert property ($changed(gen_port_rdata) |->
        $past(fifth_state_second_phase)) else $error("port sampled off its slot");
    a_state_grid: assert property (fifth_state_second_phase |-> ##2 sixth_state_second_phase
        ##1 !sixth_state_second_phase) else $error("machine state grid out of order");
endmodule // emb_bus_props

bind emb_bus_sequencer emb_bus_props emb_bus_props_i (.clock(clock), .rst_n(rst_n),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .address_latch_strobe(address_latch_strobe),
    .program_read_strobe_n(program_read_strobe_n), .data_read_strobe_n(data_read_strobe_n),
    .data_write_strobe_n(data_write_strobe_n),
    .muxed_low_address_data_port_in(muxed_low_address_data_port_in),
    .muxed_low_address_data_port_out(muxed_low_address_data_port_out),
    .muxed_low_address_data_port_oe(muxed_low_address_data_port_oe),
    .high_address_port(high_address_port), .gen_port_pins_out(gen_port_pins_out),
    .gen_port_rdata(gen_port_rdata), .fifth_state_second_phase(fifth_state_second_phase),
    .sixth_state_second_phase(sixth_state_second_phase));

/* tb/emb_memory_model.sv */
// Behavioural program and data memory behind an address latch.
`timescale 1ns/1ps
module emb_memory_model
(
    input wire logic clock,
    input wire logic ale,
    input wire logic prs_n,
    input wire logic drs_n,
    input wire logic dws_n,
    input wire logic [7:0] bus,
    input wire logic [7:0] high,
    input wire logic slow,
    output logic [7:0] mem_d
);
    logic [7:0] mem [logic [15:0]]; // Written bytes; others read as a pattern.
    logic [15:0] addr_q; // Latched address.
    logic [3:0] cnt = 4'h0; // Periods since the read strobe fell.
    logic [1:0] hold = 2'h0; // Periods left to drive after the strobe rose.
    logic [7:0] val_q = 8'h00; // Byte that would be driven.
    logic [7:0] idle_q = 8'h5a; // Toggles so a released bus never shows old data.
    logic dws_q = 1'b1; // Write strobe one edge ago.
    wire logic act = !prs_n || !drs_n;
    // Slow mode drives at the latest moment all limits allow; fast mode at once.
    // A data read meets its cycle budget two periods before its strobe limit.
    wire logic [3:0] lat = slow ? (prs_n ? 4'h3 : 4'h2) : 4'h0;

    // Drive only while a read strobe is low and the access time has run,
    // or while the hold after the strobe has not expired.
    assign mem_d = (act ? cnt >= lat : hold != 2'h0) ? val_q : idle_q;

    // ------------------------------------------------------------------
    // Address latch.
    // ------------------------------------------------------------------
    always @(negedge ale) addr_q = {high, bus};

    // ------------------------------------------------------------------
    // Access timing and storage.
    // ------------------------------------------------------------------
    always @(posedge clock)
    begin
        cnt <= act ? cnt + 4'h1 : 4'h0;
        // Keep driving one period after a fetch, two after a data read.
        hold <= act ? (prs_n ? 2'h2 : 2'h1)
            : (hold != 2'h0 ? hold - 2'h1 : 2'h0);
        idle_q <= ~idle_q;
        dws_q <= dws_n;
        val_q <= mem.exists(addr_q) ? mem[addr_q] : addr_q[7:0] ^ addr_q[15:8];
        if (!dws_q && dws_n)
        begin
            mem[addr_q] = bus;
        end
    end
endmodule // emb_memory_model

/* tb/tb_emb_bus_sequencer.sv */
// Self-checking testbench for the external bus sequencer.
`timescale 1ns/1ps
module tb_emb_bus_sequencer;
    import emb_pkg::*;
    typedef struct packed {logic [1:0] k; logic [15:0] a; logic [7:0] wd;
        logic slow; logic [1:0] stop; logic [7:0] exp;} emb_row_t;
    logic clock = 1'b0, clk_en = 1'b1, rst_n = 1'b0, req_valid = 1'b0, gen_port_wr = 1'b0;
    logic slow = 1'b0;
    logic [1:0] req_kind = 2'h0;
    logic [15:0] req_addr = 16'h0000;
    logic [7:0] req_wdata = 8'h00, gen_port_pins_in = 8'h00, gen_port_wdata = 8'h00;
    logic req_ready, rsp_valid, ale, prs_n, drs_n, dws_n, oe;
    logic [7:0] rsp_data, bus, dout, mem_d, high, pins_out, rdata;
    int error_cnt = 0, n_tests = 0, cyc = 0, lat, n;
    emb_row_t r;
    // Kind, address, write data, slow memory, clock stop (1 high, 2 low), byte.
    emb_row_t rows [8] = '{'{2'h0, 16'h12c3, 8'h00, 1'b0, 2'h0, 8'hd1},
        '{2'h0, 16'hff00, 8'h00, 1'b1, 2'h1, 8'hff}, '{2'h2, 16'h1234, 8'ha7, 1'b0, 2'h0, 8'h00},
        '{2'h1, 16'h1234, 8'h00, 1'b1, 2'h2, 8'ha7}, '{2'h1, 16'h00ff, 8'h00, 1'b0, 2'h0, 8'hff},
        '{2'h3, 16'h8001, 8'h00, 1'b1, 2'h0, 8'h81}, '{2'h2, 16'hffff, 8'h5c, 1'b1, 2'h0, 8'h00},
        '{2'h1, 16'hffff, 8'h00, 1'b0, 2'h0, 8'h5c}};

    // The clock can be halted in either level to test a stopped oscillator.
    always #50 clock = clk_en ? ~clock : clock;
    // The wire: the device wins while it drives, else the memory model.
    assign bus = oe ? dout : mem_d;

    emb_bus_sequencer emb_bus_sequencer_i (.clock(clock), .rst_n(rst_n),
        .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .address_latch_strobe(ale), .program_read_strobe_n(prs_n),
        .data_read_strobe_n(drs_n), .data_write_strobe_n(dws_n),
        .muxed_low_address_data_port_in(bus), .muxed_low_address_data_port_out(dout),
        .muxed_low_address_data_port_oe(oe), .high_address_port(high),
        .gen_port_pins_in(gen_port_pins_in), .gen_port_pins_out(pins_out),
        .gen_port_wdata(gen_port_wdata), .gen_port_wr(gen_port_wr),
        .gen_port_rdata(rdata), .fifth_state_second_phase(),
        .sixth_state_second_phase());
    emb_memory_model emb_memory_model_i (.clock(clock), .ale(ale), .prs_n(prs_n),
        .drs_n(drs_n), .dws_n(dws_n), .bus(bus), .high(high), .slow(slow), .mem_d(mem_d));

    // ------------------------------------------------------------------
    // Comparison and closing report.
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // A hang is cut short well beyond the roughly 120 cycles the run needs.
    always @(posedge clock)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clock);
        #5 chk("idle strobes", 8'h0e, {3'h0, ale, prs_n, drs_n, dws_n, oe});
        chk("port out at reset", 8'hff, pins_out);
        rst_n = 1'b1;
        // Each row is raised in the answer cycle of the one before, back to back.
        for (int i = 0; i < 8; i++)
        begin
            r = rows[i];
            chk("ready", 8'h01, {7'h0, req_ready});
            {req_kind, req_addr, req_wdata, slow, req_valid} = {r.k, r.a, r.wd, r.slow, 1'b1};
            @(posedge clock);
            #5 req_valid = 1'b0;
            lat = 0;
            while (rsp_valid !== 1'b1 && lat < 20)
            begin
                if (lat == 2)
                begin
                    chk("ready while busy", 8'h00, {7'h0, req_ready});
                    if (r.stop == 2'h2) #50;
                    if (r.stop != 2'h0) clk_en = 1'b0;
                    if (r.stop != 2'h0) #5000 clk_en = 1'b1;
                end
                @(posedge clock);
                #5 lat++;
            end
            chk("latency", (r.k[0] ^ r.k[1]) ? 8'h0d : 8'h07, 8'(lat));
            if (r.k != 2'h2) chk("rsp_data", r.exp, rsp_data);
            $display("bus row %0d done", i);
        end
        // Port pins: the source settles long before a sample and stays.
        {gen_port_wdata, gen_port_wr, gen_port_pins_in} = {8'h3c, 1'b1, 8'h96};
        @(posedge clock);
        #5 gen_port_wr = 1'b0;
        n = 0;
        while ((pins_out !== 8'h3c || rdata !== 8'h96) && n < 30)
        begin
            @(posedge clock);
            #5 n++;
        end
        chk("port out", 8'h3c, pins_out);
        chk("port sample", 8'h96, rdata);
        $display("port test done");
        // A second reset in mid-run returns ports and strobes to rest.
        rst_n = 1'b0;
        repeat (2) @(posedge clock);
        #5 chk("port out after reset", 8'hff, pins_out);
        chk("strobes after reset", 8'h0e, {3'h0, ale, prs_n, drs_n, dws_n, oe});
        rst_n = 1'b1;
        @(posedge clock);
        #5 chk("idle after reset", 8'h01, {6'h0, rsp_valid, req_ready});
        $display("reset test done");
        tally_and_finish();
    end
endmodule // tb_emb_bus_sequencer
